// *** rtl/shc_pkg.sv ***
// Shared constants and types for the sample-and-hold channel control link.
package shc_pkg;
   localparam int ADDR_W = 5;
   localparam int NUM_CH = 32;
   localparam int DATA_W = 8;
   // Serial frame: mode(2) + address(5) + data(8) bits, MSB first.
   localparam int FRAME_BITS = 15;
   localparam int SCLK_MAX_MHZ = 20;
   localparam int REF_MHZ = 25;
   localparam int LINK_DIV = 2;
   localparam int ACQ_US = 16;
   localparam int ACQ_CYC = ACQ_US * REF_MHZ;
   localparam int RST_MIN_NS = 90;
   localparam int RST_MAX_NS = 200;
   localparam int REF_NS = 40;
   localparam int RST_MIN_CYC = (RST_MIN_NS + REF_NS - 1) / REF_NS;
   localparam int RST_MAX_CYC = RST_MAX_NS / REF_NS;
   localparam logic [DATA_W-1:0] CH_RESET = 8'h00;
   localparam logic [1:0] MODE_WRITE = 2'h0;
   localparam logic [1:0] MODE_READ = 2'h1;
   localparam logic [1:0] MODE_ALL = 2'h2;
   localparam logic [1:0] MODE_OFFS = 2'h3;
endpackage : shc_pkg

// *** rtl/shc_if.sv ***
// Pin-level link between the host and the channel control device.
`timescale 1ns/100ps
`default_nettype none
interface shc_if;
   logic [4:0] channel_address_pins;
   logic all_acquire;
   logic sel_sync_n;
   logic wr_n;
   logic offset_sel;
   logic sclk;
   logic sdin;
   logic sdout;
   logic interface_select;
   logic busy_n;
   logic track_rst_n;
   modport device (
      input channel_address_pins, all_acquire, sel_sync_n, wr_n,
      input offset_sel, sclk, sdin, interface_select, track_rst_n,
      output sdout, busy_n
   );
   modport host (
      output channel_address_pins, all_acquire, sel_sync_n, wr_n,
      output offset_sel, sclk, sdin, interface_select, track_rst_n,
      input sdout, busy_n
   );
endinterface : shc_if
`default_nettype wire

// *** rtl/shc_device.sv ***
// Channel control device end: decoding, acquisition sequencing, readback.
//
// Overview of operation
// - Five-bit address selects one of 32 channels.
// - All-acquire input loads every channel together.
// - Select pin is chip select or frame sync.
// - Host drives write strobe with chip select.
// - Offset select targets the offset channel.
// - Host keeps shift clock at most 20 MHz.
// - Serial data sampled on falling shift edge.
// - Readback bit shifted on rising edge.
// - Interface select low parallel, high serial.
// - Busy low during acquisition, high after.
// - Track high: acquire once channel addressed.
// - Track low: input routed straight through.
// - Track rising edge starts addressed acquisition.
// - Track low pulse 90-200 ns resets device.
// - Acquisition completes within 16 microseconds.
// - Power-on clears all channel registers.
// - Upper address, strobes, selects default low.
// - Lowest address, serial, track default high.
`timescale 1ns/100ps
`default_nettype none
module shc_device #(
   parameter int ACQ_CYCLES = shc_pkg::ACQ_CYC
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   shc_if.device LINK,
   input wire logic [shc_pkg::DATA_W-1:0] COMMON_ANALOG_INPUT_I,
   output logic [shc_pkg::DATA_W-1:0] OFFSET_CHANNEL_OUTPUT_O,
   output logic [shc_pkg::DATA_W-1:0] STAGE_INPUT_O,
   output logic [shc_pkg::DATA_W*shc_pkg::NUM_CH-1:0] CHANNELS_O
);
   localparam int DW = shc_pkg::DATA_W;
   localparam int NC = shc_pkg::NUM_CH;

   typedef enum logic [1:0] {ST_IDLE, ST_ACQ} shc_st_e;
   typedef struct packed {
      logic [1:0] s_addr_sync, s_all_sync, s_cs_sync, s_wr_sync;
      logic [1:0] s_offs_sync, s_mode_sync, s_trk_sync;
      logic [1:0] s_flag_sync;
      logic wr_q, trk_q, flag_q;
      logic [3:0] low_cnt;
      logic [4:0] addr;
      logic all, offs, armed;
      shc_st_e st;
      logic [15:0] cnt;
      logic busy_n;
      logic [DW-1:0] stage, offs_ch;
      logic [DW*NC-1:0] ch;
   } shc_dev_s;

   shc_dev_s st_r, st_nxt;
   logic [4:0] a_s1_r, a_s2_r;
   logic [DW-1:0] rb_word;

   // Address bits are a bus; each bit gets its own two-stage synchroniser.
   always_ff @(posedge REF_CLK_I) begin
      a_s1_r <= LINK.channel_address_pins;
      a_s2_r <= a_s1_r;
   end

   // Serial shifter runs on the link's own clock, which stands still between
   // frames, so select rising is the only moment to clear it. A frame-done
   // level hands the frame over; the reference side acts on its rise.
   logic [shc_pkg::FRAME_BITS-1:0] sh_r;
   logic [4:0] bit_r;
   logic flag_r;
   logic [shc_pkg::FRAME_BITS-1:0] frame_r;
   logic [DW-1:0] rb_r;
   logic sdout_r;
   logic [DW-1:0] rb_s1_r, rb_s2_r;

   always_ff @(negedge LINK.sclk or posedge LINK.sel_sync_n) begin
      if (LINK.sel_sync_n) begin
         bit_r <= 5'h00;
         flag_r <= 1'b0;
         sh_r <= '0;
         frame_r <= '0;
      end else if (LINK.interface_select) begin
         sh_r <= {sh_r[shc_pkg::FRAME_BITS-2:0], LINK.sdin};
         if (bit_r != 5'h1f) begin
            bit_r <= bit_r + 5'h01;
         end
         if (bit_r == 5'(shc_pkg::FRAME_BITS - 1)) begin
            frame_r <= {sh_r[shc_pkg::FRAME_BITS-2:0], LINK.sdin};
            flag_r <= 1'b1;
         end
      end
   end

   // Readback word crosses as a quasi-static value: it moves only when an
   // acquisition ends, a reset pulse clears the channels or a channel is addressed, so a read frame returns
   // the channel addressed before it. The host must wait for busy high.
   always_ff @(posedge LINK.sclk) begin
      rb_s1_r <= rb_word;
      rb_s2_r <= rb_s1_r;
      if (bit_r == 5'(shc_pkg::FRAME_BITS)) begin
         sdout_r <= rb_s2_r[DW-1];
         rb_r <= {rb_s2_r[DW-2:0], 1'b0};
      end else begin
         sdout_r <= rb_r[DW-1];
         rb_r <= {rb_r[DW-2:0], 1'b0};
      end
   end
   assign LINK.sdout = sdout_r;

   always_comb begin
      rb_word = st_r.ch[st_r.addr*DW +: DW];
   end

   always_comb begin
      logic par_go, ser_go, trk_rise, rst_pulse;
      logic [4:0] a;
      logic [1:0] md;
      st_nxt = st_r;
      par_go = 1'b0;
      ser_go = 1'b0;
      rst_pulse = 1'b0;
      a = a_s2_r;
      md = frame_r[shc_pkg::FRAME_BITS-1 -: 2];
      st_nxt.s_all_sync = {st_r.s_all_sync[0], LINK.all_acquire};
      st_nxt.s_cs_sync = {st_r.s_cs_sync[0], LINK.sel_sync_n};
      st_nxt.s_wr_sync = {st_r.s_wr_sync[0], LINK.wr_n};
      st_nxt.s_offs_sync = {st_r.s_offs_sync[0], LINK.offset_sel};
      st_nxt.s_mode_sync = {st_r.s_mode_sync[0], LINK.interface_select};
      st_nxt.s_trk_sync = {st_r.s_trk_sync[0], LINK.track_rst_n};
      st_nxt.s_flag_sync = {st_r.s_flag_sync[0], flag_r};
      st_nxt.wr_q = st_r.s_wr_sync[1] | st_r.s_cs_sync[1];
      st_nxt.trk_q = st_r.s_trk_sync[1];
      st_nxt.flag_q = st_r.s_flag_sync[1];
      trk_rise = st_r.s_trk_sync[1] & ~st_r.trk_q;
      // Parallel write takes on the strobe's falling edge under select.
      if (!st_r.s_mode_sync[1] && st_r.wr_q &&
          !st_r.s_wr_sync[1] && !st_r.s_cs_sync[1]) begin
         par_go = 1'b1;
         st_nxt.addr = a;
         st_nxt.all = st_r.s_all_sync[1];
         st_nxt.offs = st_r.s_offs_sync[1];
      end
      if (st_r.s_mode_sync[1] && st_r.s_flag_sync[1] && !st_r.flag_q) begin
         st_nxt.addr = frame_r[DW +: 5];
         if (md != shc_pkg::MODE_READ) begin
            ser_go = 1'b1;
            st_nxt.all = (md == shc_pkg::MODE_ALL);
            st_nxt.offs = (md == shc_pkg::MODE_OFFS);
         end
      end
      // Low-time counter on track/reset picks out short reset pulses.
      if (!st_r.s_trk_sync[1]) begin
         if (st_r.low_cnt != 4'hf) begin
            st_nxt.low_cnt = st_r.low_cnt + 4'h1;
         end
      end else begin
         st_nxt.low_cnt = 4'h0;
         if (trk_rise && st_r.low_cnt >= 4'(shc_pkg::RST_MIN_CYC - 1) &&
             st_r.low_cnt <= 4'(shc_pkg::RST_MAX_CYC + 1)) begin
            rst_pulse = 1'b1;
         end
      end
      // While track is low the stage follows the input directly.
      if (!st_r.s_trk_sync[1] || st_r.st == ST_ACQ) begin
         st_nxt.stage = COMMON_ANALOG_INPUT_I;
      end else begin
         st_nxt.stage = st_r.offs ? st_r.offs_ch : rb_word;
      end
      case (st_r.st)
         ST_IDLE: begin
            if (par_go || ser_go) begin
               st_nxt.armed = 1'b1;
            end
            if ((st_nxt.armed && st_r.s_trk_sync[1])
                || (trk_rise && !rst_pulse)) begin
               st_nxt.armed = 1'b0;
               st_nxt.st = ST_ACQ;
               st_nxt.cnt = 16'h0;
               st_nxt.busy_n = 1'b0;
            end
         end
         ST_ACQ: begin
            st_nxt.cnt = st_r.cnt + 16'h1;
            if (st_r.cnt == 16'(ACQ_CYCLES - 1)) begin
               st_nxt.st = ST_IDLE;
               st_nxt.busy_n = 1'b1;
               if (st_r.offs) begin
                  st_nxt.offs_ch = COMMON_ANALOG_INPUT_I;
               end else if (st_r.all) begin
                  for (int i = 0; i < NC; i++) begin
                     st_nxt.ch[i*DW +: DW] = COMMON_ANALOG_INPUT_I;
                  end
               end else begin
                  st_nxt.ch[st_r.addr*DW +: DW] = COMMON_ANALOG_INPUT_I;
               end
            end
         end
         default: st_nxt.st = ST_IDLE;
      endcase
      if (rst_pulse) begin
         st_nxt.st = ST_IDLE;
         st_nxt.busy_n = 1'b1;
         st_nxt.armed = 1'b0;
         st_nxt.offs_ch = shc_pkg::CH_RESET;
         st_nxt.ch = {NC{shc_pkg::CH_RESET}};
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         st_r <= '0;
         st_r.s_wr_sync <= 2'b11;
         // Track idles high; starting its synchroniser low would fake a rise.
         st_r.s_trk_sync <= 2'b11;
         st_r.trk_q <= 1'b1;
         st_r.s_cs_sync <= 2'b11;
         st_r.wr_q <= 1'b1;
         st_r.busy_n <= 1'b1;
         st_r.st <= ST_IDLE;
         st_r.ch <= {NC{shc_pkg::CH_RESET}};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign LINK.busy_n = st_r.busy_n;
   assign OFFSET_CHANNEL_OUTPUT_O = st_r.offs_ch;
   assign STAGE_INPUT_O = st_r.stage;
   assign CHANNELS_O = st_r.ch;
endmodule // shc_device
`default_nettype wire

// *** rtl/shc_host.sv ***
// Host end: drives channel selection by parallel strobe or serial frame.
`timescale 1ns/100ps
`default_nettype none
module shc_host (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   shc_if.host LINK,
   input wire logic REQ_I,
   input wire logic SERIAL_I,
   input wire logic [1:0] MODE_I,
   input wire logic [4:0] ADDR_I,
   input wire logic TRACK_I,
   output logic DONE_O,
   output logic BUSY_N_O,
   output logic [shc_pkg::DATA_W-1:0] RDATA_O
);
   localparam int FB = shc_pkg::FRAME_BITS;
   localparam int DW = shc_pkg::DATA_W;
   typedef enum logic [2:0] {H_IDLE, H_PAR, H_PAR2, H_SER} shc_hst_e;
   typedef struct packed {
      shc_hst_e st;
      logic [4:0] addr;
      logic all, offs, wr_n, cs_n, ser, sclk, sdin, done;
      logic [FB+DW-1:0] sh;
      logic [5:0] bits;
      logic [1:0] busy_sync, sdo_sync;
      logic busy;
      logic [DW-1:0] rd;
   } shc_host_s;
   shc_host_s h_r, h_nxt;

   always_comb begin
      h_nxt = h_r;
      h_nxt.done = 1'b0;
      h_nxt.busy_sync = {h_r.busy_sync[0], LINK.busy_n};
      h_nxt.busy = h_r.busy_sync[1];
      h_nxt.sdo_sync = {h_r.sdo_sync[0], LINK.sdout};
      case (h_r.st)
         H_IDLE: begin
            h_nxt.cs_n = 1'b1;
            h_nxt.wr_n = 1'b1;
            h_nxt.sclk = 1'b1;
            if (REQ_I) begin
               h_nxt.ser = SERIAL_I;
               h_nxt.addr = ADDR_I;
               h_nxt.all = (MODE_I == shc_pkg::MODE_ALL);
               h_nxt.offs = (MODE_I == shc_pkg::MODE_OFFS);
               h_nxt.sh = {MODE_I, ADDR_I, {(DW+DW){1'b0}}};
               h_nxt.bits = 6'h0;
               h_nxt.st = SERIAL_I ? H_SER : H_PAR;
            end
         end
         H_PAR: begin
            h_nxt.cs_n = 1'b0;
            h_nxt.wr_n = 1'b0;
            h_nxt.st = H_PAR2;
         end
         H_PAR2: begin
            h_nxt.cs_n = 1'b1;
            h_nxt.wr_n = 1'b1;
            h_nxt.done = 1'b1;
            h_nxt.st = H_IDLE;
         end
         H_SER: begin
            // Toggling every cycle gives 12.5 MHz. Data moves with the
            // rising edge so it is settled at the falling one, and the
            // shift clock only runs while select is low.
            h_nxt.cs_n = 1'b0;
            if (h_r.cs_n) begin
               h_nxt.sdin = h_r.sh[FB+DW-1];
               h_nxt.sh = {h_r.sh[FB+DW-2:0], 1'b0};
            end else if (!h_r.sclk) begin
               h_nxt.sclk = 1'b1;
               h_nxt.sdin = h_r.sh[FB+DW-1];
               h_nxt.sh = {h_r.sh[FB+DW-2:0], 1'b0};
            end else begin
               // The synchronised readback bit is two reference clock periods (one shift clock period) late.
               if (h_r.bits > 6'(FB)) begin
                  h_nxt.rd = {h_r.rd[DW-2:0], h_r.sdo_sync[1]};
               end
               if (h_r.bits != 6'(FB + DW)) begin
                  h_nxt.sclk = 1'b0;
                  h_nxt.bits = h_r.bits + 6'h1;
               end else begin
                  h_nxt.st = H_IDLE;
                  h_nxt.cs_n = 1'b1;
                  h_nxt.done = 1'b1;
               end
            end
         end
         default: h_nxt.st = H_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         h_r <= '0;
         h_r.st <= H_IDLE;
         h_r.cs_n <= 1'b1;
         h_r.wr_n <= 1'b1;
         h_r.sclk <= 1'b1;
         h_r.sdin <= 1'b1;
         h_r.busy <= 1'b1;
         h_r.busy_sync <= 2'b11;
      end else begin
         h_r <= h_nxt;
      end
   end

   assign LINK.channel_address_pins = h_r.addr;
   assign LINK.all_acquire = h_r.all;
   assign LINK.offset_sel = h_r.offs;
   assign LINK.wr_n = h_r.wr_n;
   assign LINK.sel_sync_n = h_r.cs_n;
   assign LINK.interface_select = h_r.ser;
   assign LINK.sclk = h_r.sclk;
   assign LINK.sdin = h_r.sdin;
   assign LINK.track_rst_n = TRACK_I;
   assign DONE_O = h_r.done;
   assign BUSY_N_O = h_r.busy;
   assign RDATA_O = h_r.rd;
endmodule // shc_host
`default_nettype wire

// *** verification/shc_chk.sv ***
// Assertions on the host-to-device channel control link.
`timescale 1ns/100ps
`default_nettype none
module shc_chk #(
   parameter int ACQ_CYCLES = 20
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic sel_sync_n,
   input wire logic wr_n,
   input wire logic sclk,
   input wire logic sdin,
   input wire logic interface_select,
   input wire logic busy_n,
   input wire logic track_rst_n
);
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RST_I);
   // Counts cycles of the current acquisition, so the bound is exact.
   logic [15:0] low_r;
   always_ff @(posedge REF_CLK_I) begin
      low_r <= (RST_I || busy_n) ? 16'h0000 : low_r + 16'h0001;
   end
   sequence acq_hold_s;
      !busy_n [*8];
   endsequence
   sequence par_strobe_s;
      !interface_select && $fell(wr_n) && !sel_sync_n && track_rst_n && busy_n;
   endsequence
   busy_max_a: assert property (busy_n || low_r < 16'(ACQ_CYCLES))
      else $error("acquisition ran too long");
   busy_hold_a: assert property ($fell(busy_n) |-> ##1 acq_hold_s)
      else $error("busy released early");
   acq_start_a: assert property (par_strobe_s |-> ##[1:12] !busy_n)
      else $error("strobe did not start acquisition");
   busy_track_a: assert property ($fell(busy_n) |-> track_rst_n)
      else $error("acquisition began with track low");
   idle_reset_a: assert property ($fell(RST_I) |-> busy_n)
      else $error("busy low after reset");
   strobe_cs_a: assert property ($fell(wr_n) |-> !sel_sync_n)
      else $error("write strobe without select");
   par_only_a: assert property ($fell(wr_n) |-> !interface_select)
      else $error("write strobe in serial mode");
   sclk_frame_a: assert property ($fell(sclk) |-> !sel_sync_n)
      else $error("shift clock outside frame");
   sclk_rate_a: assert property ($rose(sclk) |=> !$rose(sclk))
      else $error("shift clock too fast");
   sdin_hold_a: assert property ($fell(sclk) |-> $stable(sdin))
      else $error("serial data moved at falling edge");
endmodule // shc_chk
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench joining the host and device ends of the link.
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int ACQ = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic ser = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [4:0] addr = 5'h00;
   logic trk = 1'b1;
   logic [7:0] common_analog_input = 8'h00;
   logic done, bsy_n;
   logic [7:0] rdata, offs, stage;
   logic [255:0] chans;
   int error_cnt = 0;
   int n_checks = 0;
   int len;
   shc_if lnk ();
   shc_host shc_host_i (.REF_CLK_I(clk), .RST_I(rst), .LINK(lnk),
      .REQ_I(req), .SERIAL_I(ser), .MODE_I(mode), .ADDR_I(addr),
      .TRACK_I(trk), .DONE_O(done), .BUSY_N_O(bsy_n), .RDATA_O(rdata));
   shc_device #(.ACQ_CYCLES(ACQ)) shc_device_i (.REF_CLK_I(clk),
      .RST_I(rst), .LINK(lnk), .COMMON_ANALOG_INPUT_I(common_analog_input),
      .OFFSET_CHANNEL_OUTPUT_O(offs), .STAGE_INPUT_O(stage),
      .CHANNELS_O(chans));
   shc_chk #(.ACQ_CYCLES(ACQ)) shc_chk_i (.REF_CLK_I(clk), .RST_I(rst),
      .sel_sync_n(lnk.sel_sync_n), .wr_n(lnk.wr_n), .sclk(lnk.sclk),
      .sdin(lnk.sdin), .interface_select(lnk.interface_select),
      .busy_n(lnk.busy_n), .track_rst_n(lnk.track_rst_n));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic send(input logic s, input logic [1:0] m,
                       input logic [4:0] a);
      int i;
      ser = s;
      mode = m;
      addr = a;
      req = 1'b1;
      tick(1);
      req = 1'b0;
      for (i = 0; i < 200 && done !== 1'b1; i++) tick(1);
      if (done !== 1'b1) begin
         chk(16'h0, 16'h1);
         give_verdict();
      end
      tick(1);
   endtask
   // Leaves the count of busy cycles in len; zero means no acquisition.
   task automatic acq();
      int i;
      len = 0;
      for (i = 0; i < 30 && bsy_n !== 1'b0; i++) tick(1);
      while (bsy_n === 1'b0) begin
         len++;
         tick(1);
         if (len > ACQ + 10) begin
            chk(16'h0, 16'h1);
            give_verdict();
         end
      end
   endtask
   task automatic zeros();
      for (int i = 0; i < 32; i++) chk(chans[8*i+:8], 8'h00);
      chk(offs, 8'h00);
      chk(bsy_n, 1'b1);
   endtask
   task automatic t_par();
      logic [4:0] a [3] = '{5'h00, 5'h1f, 5'h12};
      logic [7:0] v [3] = '{8'h3c, 8'hc3, 8'h5a};
      for (int i = 0; i < 3; i++) begin
         common_analog_input = v[i];
         send(1'b0, shc_pkg::MODE_WRITE, a[i]);
         acq();
         chk(16'(len > 0 && len <= ACQ), 16'h1);
         chk(chans[8*a[i]+:8], v[i]);
      end
      $display("parallel write test done");
   endtask
   task automatic t_all();
      common_analog_input = 8'h77;
      send(1'b0, shc_pkg::MODE_ALL, 5'h00);
      acq();
      for (int i = 0; i < 32; i++) chk(chans[8*i+:8], 8'h77);
      common_analog_input = 8'h29;
      send(1'b0, shc_pkg::MODE_OFFS, 5'h04);
      acq();
      chk(offs, 8'h29);
      chk(chans[32+:8], 8'h77);
      $display("all-channel and offset test done");
   endtask
   task automatic t_ser();
      common_analog_input = 8'ha5;
      send(1'b1, shc_pkg::MODE_WRITE, 5'h09);
      acq();
      chk(chans[72+:8], 8'ha5);
      send(1'b1, shc_pkg::MODE_READ, 5'h09);
      chk(rdata, 8'ha5);
      $display("serial test done");
   endtask
   task automatic t_track();
      ser = 1'b0;
      trk = 1'b0;
      common_analog_input = 8'h4e;
      tick(8);
      chk(stage, 8'h4e);
      send(1'b0, shc_pkg::MODE_WRITE, 5'h03);
      acq();
      chk(16'(len), 16'h0);
      trk = 1'b1;
      acq();
      chk(16'(len > 0), 16'h1);
      chk(chans[24+:8], 8'h4e);
      // A 160 ns low pulse sits inside the reset window.
      trk = 1'b0;
      tick(4);
      trk = 1'b1;
      tick(12);
      zeros();
      $display("track and reset test done");
   endtask
   initial begin
      forever #20 clk = ~clk;
   end
   initial begin
      tick(3);
      rst = 1'b0;
      tick(2);
      zeros();
      t_par();
      t_all();
      t_ser();
      t_track();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
